// *** chip_config_rx_irq_mask.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Read-only identity register: die revision high nibble, part digit low.
// - Setup bit 7 picks signal-absent pin drive: 0 push-pull, 1 open-drain.
// - Setup bit 6 picks interrupt pin drive: 0 push-pull, 1 open-drain.
// - Setup bit 5 gates all interrupts; 0 means none are signalled.
// - Setup bit 4 picks serial data out drive: 0 CMOS, 1 open-drain.
// - Setup bit 2 enables optical-side loopback; 0 is normal.
// - Setup bit 1 enables host-side electrical loopback; 0 is normal.
// - Setup bit 0 chooses reference rate: 0 is 155 MHz, 1 is 622 MHz.
// - Receiver register bit 0 puts receiver to sleep; bits 7:1 read zero.
// - Mask bit 6 masks reference-clock-absent alarm; mask bit 7 reads zero.
// - Mask bit 5 masks the signal-absent alarm.
// - Mask bit 4 masks the loss-of-lock alarm.
// - Mask bit 3 masks buffer fault; reads zero while self-clear is on.
// - Mask bit 2 masks the pattern error alarm.
// - Mask bit 1 masks the pattern sync lost alarm.
// - Mask bit 0 masks the signal quality alarm.
// - Sticky alarm bits; write zero clears one, interrupt disable clears all.
module chip_config_rx_irq_mask (
  input wire logic clk,
  input wire logic rst,
  input wire xcvr_cfg_pkg::bus_req_type bus_req,
  output xcvr_cfg_pkg::bus_rsp_type bus_rsp,
  input wire logic [xcvr_cfg_pkg::ALARM_W-1:0] alarm_in,
  output xcvr_cfg_pkg::chip_ctrl_type ctrl,
  output logic irq_out,
  output logic irq_oe
);
  import xcvr_cfg_pkg::*;

  logic [7:0] setup_reg;
  logic receiver_sleep_reg;
  logic [ALARM_W-1:0] mask_reg;
  logic [ALARM_W-1:0] status_reg;
  logic buf_self_clear_reg;
  logic recal_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic ack_reg;
  logic [ALARM_W-1:0] mask_view;
  logic [ALARM_W-1:0] pending;
  logic wr_hit;
  logic rd_hit;
  logic irq_next;
  logic [7:0] wbyte;
  logic sel_setup;
  logic sel_power;
  logic sel_masks;
  logic sel_status;
  logic sel_buf;
  logic wr_setup;
  logic wr_power;
  logic wr_masks;
  logic wr_status;
  logic wr_buf;
  logic [7:0] rd_byte;
  logic irq_oe_next;

  // Alarm masks and status must each fit in one register byte.
  if (ALARM_W < 1 || ALARM_W > 7) begin : g_alarm_width
    $error("alarm count does not fit a register byte");
  end

  // The register byte lane must exist on the data bus.
  if (DATA_W < 8) begin : g_data_width
    $error("data bus narrower than a register byte");
  end

  // Each access takes one wait cycle; the answer comes in the second cycle.
  // A write lands at the edge where the host sees waitrequest low.
  assign wr_hit = bus_req.write && ack_reg;
  assign rd_hit = bus_req.read && !ack_reg;
  assign wbyte = bus_req.writedata[7:0];

  // Register selects from the word index.
  assign sel_setup = bus_req.address == IDX_SETUP;
  assign sel_power = bus_req.address == IDX_RX_POWER;
  assign sel_masks = bus_req.address == IDX_MASKS;
  assign sel_status = bus_req.address == IDX_STATUS;
  assign sel_buf = bus_req.address == IDX_BUF_CTRL;

  assign wr_setup = wr_hit && sel_setup;
  assign wr_power = wr_hit && sel_power;
  assign wr_masks = wr_hit && sel_masks;
  assign wr_status = wr_hit && sel_status;
  assign wr_buf = wr_hit && sel_buf;

  always_comb begin
    mask_view = mask_reg;
    if (buf_self_clear_reg) begin
      mask_view[ALM_RX_BUFFER_FAULT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (bus_req.read || bus_req.write) && !ack_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_reg <= SETUP_RESET;
    end else if (wr_setup) begin
      setup_reg <= wbyte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      receiver_sleep_reg <= 1'b0;
    end else if (wr_power) begin
      receiver_sleep_reg <= wbyte[RX_SLEEP_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= MASK_RESET;
    end else if (wr_masks) begin
      mask_reg <= wbyte[ALARM_W-1:0];
    end
  end

  // Buffer self-clear also forces the fault mask bit to read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_self_clear_reg <= 1'b0;
    end else if (wr_buf) begin
      buf_self_clear_reg <= wbyte[BUF_SELF_CLEAR_BIT];
    end
  end

  // Recalibration is a one-cycle strobe; the bit itself reads zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recal_reg <= 1'b0;
    end else begin
      recal_reg <= wr_buf && wbyte[BUF_RECAL_BIT];
    end
  end

  // Sticky alarms: a new event wins over a clear in the same cycle.
  for (genvar i = 0; i < ALARM_W; i++) begin : g_alarm
    alarm_sticky_bit #(
      .CLEAR_LEVEL(1'b0)
    ) latch (
      .clk(clk),
      .rst(rst),
      .event_in(alarm_in[i]),
      .gate_on(setup_reg[SETUP_IRQ_GATE]),
      .write_en(wr_status),
      .write_bit(wbyte[i]),
      .mask_bit(mask_view[i]),
      .status_bit(status_reg[i]),
      .pending_bit(pending[i])
    );
  end

  // Interrupt uses the effective mask, so a self-cleared fault bit unmasks.
  assign irq_next = setup_reg[SETUP_IRQ_GATE] && |pending;

  // Open-drain drives only the asserted level; push-pull always drives.
  assign irq_oe_next = setup_reg[SETUP_IRQ_DRIVE] ? irq_next : 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= irq_oe_next;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (bus_req.address)
      IDX_IDENT: begin
        rd_byte = {DIE_REVISION, PART_DIGIT};
      end
      IDX_SETUP: begin
        rd_byte = setup_reg;
      end
      IDX_RX_POWER: begin
        rd_byte[RX_SLEEP_BIT] = receiver_sleep_reg;
      end
      IDX_MASKS: begin
        rd_byte[ALARM_W-1:0] = mask_view;
      end
      IDX_STATUS: begin
        rd_byte[ALARM_W-1:0] = status_reg;
      end
      IDX_BUF_CTRL: begin
        rd_byte[BUF_SELF_CLEAR_BIT] = buf_self_clear_reg;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read data is loaded in the wait cycle and stands until the next read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (rd_hit) begin
      rdata_reg <= {{(DATA_W-8){1'b0}}, rd_byte};
    end
  end

  always_comb begin
    bus_rsp.readdata = rdata_reg;
    bus_rsp.waitrequest = (bus_req.read || bus_req.write) && !ack_reg;
  end

  // Control levels follow their register bits one cycle later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.signal_absent_pin_drive <= 1'b0;
    end else begin
      ctrl.signal_absent_pin_drive <= setup_reg[SETUP_SIGNAL_ABSENT_DRIVE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.irq_pin_drive <= 1'b0;
    end else begin
      ctrl.irq_pin_drive <= setup_reg[SETUP_IRQ_DRIVE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.host_sdo_pin_drive <= 1'b0;
    end else begin
      ctrl.host_sdo_pin_drive <= setup_reg[SETUP_SDO_DRIVE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.optical_side_loop <= 1'b0;
    end else begin
      ctrl.optical_side_loop <= setup_reg[SETUP_OPTICAL_LOOP];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.host_side_loop <= 1'b0;
    end else begin
      ctrl.host_side_loop <= setup_reg[SETUP_HOST_LOOP];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.ref_rate_select <= 1'b0;
    end else begin
      ctrl.ref_rate_select <= setup_reg[SETUP_REF_RATE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.receiver_sleep <= 1'b0;
    end else begin
      ctrl.receiver_sleep <= receiver_sleep_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.buffer_self_clear <= 1'b0;
    end else begin
      ctrl.buffer_self_clear <= buf_self_clear_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl.full_recalibration <= 1'b0;
    end else begin
      ctrl.full_recalibration <= recal_reg;
    end
  end

endmodule

// One sticky alarm bit and its masked pending flag.
module alarm_sticky_bit #(
  parameter logic CLEAR_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic event_in,
  input wire logic gate_on,
  input wire logic write_en,
  input wire logic write_bit,
  input wire logic mask_bit,
  output logic status_bit,
  output logic pending_bit
);
  logic status_next;

  // Disabling interrupts clears; a new event still wins in that cycle.
  always_comb begin
    status_next = status_bit;
    if (!gate_on) begin
      status_next = 1'b0;
    end else if (write_en && write_bit == CLEAR_LEVEL) begin
      status_next = 1'b0;
    end
    status_next = status_next | event_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_bit <= 1'b0;
    end else begin
      status_bit <= status_next;
    end
  end

  // A masked bit stays latched but raises nothing.
  assign pending_bit = status_bit && !mask_bit;

endmodule

// *** xcvr_cfg_pkg.sv ***
package xcvr_cfg_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int ALARM_W = 7;

  // Word indices of the registers; byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_IDENT = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_SETUP = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_RX_POWER = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_MASKS = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_BUF_CTRL = 4'h6;

  // Fields of global_chip_setup.
  localparam int SETUP_SIGNAL_ABSENT_DRIVE = 7;
  localparam int SETUP_IRQ_DRIVE = 6;
  localparam int SETUP_IRQ_GATE = 5;
  localparam int SETUP_SDO_DRIVE = 4;
  localparam int SETUP_RESERVED_ONE = 3;
  localparam int SETUP_OPTICAL_LOOP = 2;
  localparam int SETUP_HOST_LOOP = 1;
  localparam int SETUP_REF_RATE = 0;
  localparam logic [7:0] SETUP_RESET = 8'h08;

  // Alarm bit positions, shared by masks and latched status.
  localparam int ALM_REF_CLOCK_ABSENT = 6;
  localparam int ALM_SIGNAL_ABSENT = 5;
  localparam int ALM_LOSS_OF_LOCK = 4;
  localparam int ALM_RX_BUFFER_FAULT = 3;
  localparam int ALM_PATTERN_ERROR = 2;
  localparam int ALM_PATTERN_SYNC_LOST = 1;
  localparam int ALM_SIGNAL_QUALITY = 0;
  localparam logic [ALARM_W-1:0] MASK_RESET = 7'h00;

  localparam int RX_SLEEP_BIT = 0;
  localparam int BUF_SELF_CLEAR_BIT = 1;
  localparam int BUF_RECAL_BIT = 3;

  // Identity values are arbitrary.
  localparam logic [3:0] DIE_REVISION = 4'h5;
  localparam logic [3:0] PART_DIGIT = 4'ha;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
  } bus_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } bus_rsp_type;

  typedef struct packed {
    logic signal_absent_pin_drive;
    logic irq_pin_drive;
    logic host_sdo_pin_drive;
    logic optical_side_loop;
    logic host_side_loop;
    logic ref_rate_select;
    logic receiver_sleep;
    logic buffer_self_clear;
    logic full_recalibration;
  } chip_ctrl_type;

endpackage

// *** xcvr_cfg_chk.sv ***
`timescale 1ns/1ps
module xcvr_cfg_chk (
  input wire logic clk,
  input wire logic rst,
  input wire xcvr_cfg_pkg::bus_req_type bus_req,
  input wire xcvr_cfg_pkg::bus_rsp_type bus_rsp,
  input wire logic [xcvr_cfg_pkg::ALARM_W-1:0] alarm_in,
  input wire xcvr_cfg_pkg::chip_ctrl_type ctrl,
  input wire logic irq_out,
  input wire logic irq_oe
);
  import xcvr_cfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_ok = bus_req.read && !bus_rsp.waitrequest;
  wire wr_ok = bus_req.write && !bus_rsp.waitrequest;
  AST_WAIT: assert property ($rose(bus_req.read | bus_req.write)
    |-> bus_rsp.waitrequest ##1 !bus_rsp.waitrequest) else $error("wait off");
  AST_IDENT: assert property (rd_ok && bus_req.address == IDX_IDENT
    |-> bus_rsp.readdata == {24'h0, DIE_REVISION, PART_DIGIT})
    else $error("identity value wrong");
  AST_RX_POWER: assert property (rd_ok && bus_req.address == IDX_RX_POWER
    |-> bus_rsp.readdata[31:1] == '0) else $error("sleep upper bits set");
  AST_MASK_TOP: assert property (rd_ok && bus_req.address == IDX_MASKS
    |-> bus_rsp.readdata[31:7] == '0) else $error("mask top bit set");
  AST_SETUP: assert property (wr_ok && bus_req.address == IDX_SETUP
    |-> ##2 {ctrl.signal_absent_pin_drive, ctrl.host_sdo_pin_drive,
    ctrl.optical_side_loop, ctrl.host_side_loop, ctrl.ref_rate_select} ==
    {$past(bus_req.writedata[7], 2), $past(bus_req.writedata[4], 2),
    $past(bus_req.writedata[2:0], 2)}) else $error("setup fields wrong");
  AST_SLEEP: assert property (wr_ok && bus_req.address == IDX_RX_POWER
    |-> ##2 ctrl.receiver_sleep == $past(bus_req.writedata[0], 2))
    else $error("sleep not taken");
  AST_RECAL: assert property (wr_ok && bus_req.address == IDX_BUF_CTRL
    && bus_req.writedata[BUF_RECAL_BIT] |-> ##2 ctrl.full_recalibration
    ##1 !ctrl.full_recalibration) else $error("recalibration pulse wrong");
  AST_OE_PUSH: assert property (!ctrl.irq_pin_drive [*3] |-> irq_oe)
    else $error("push-pull enable low");
  AST_OE_OPEN: assert property (ctrl.irq_pin_drive [*3]
    |-> irq_oe == irq_out) else $error("open-drain enable wrong");
endmodule
bind chip_config_rx_irq_mask xcvr_cfg_chk chk (.clk(clk), .rst(rst),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .alarm_in(alarm_in), .ctrl(ctrl),
  .irq_out(irq_out), .irq_oe(irq_oe));

// *** host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  output xcvr_cfg_pkg::bus_req_type req,
  input wire xcvr_cfg_pkg::bus_rsp_type rsp
);
  import xcvr_cfg_pkg::*;
  initial req = '0;
  task automatic acc(input logic w, input logic [3:0] a,
      input logic [7:0] wd, output logic [7:0] q);
    @(posedge clk);
    req <= '{address: a, read: !w, write: w, writedata: {24'h0, wd}};
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata[7:0];
    req <= '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    if (a == IDX_SETUP) d[SETUP_RESERVED_ONE] = 1'b1;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    acc(1'b0, a, 8'h00, q);
  endtask
endmodule

// *** chip_config_rx_irq_mask_tb.sv ***
`timescale 1ns/1ps
module chip_config_rx_irq_mask_tb;
  import xcvr_cfg_pkg::*;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
  logic clk = 0;
  logic rst = 1;
  logic [ALARM_W-1:0] alarm_in = '0;
  bus_req_type bus_req;
  bus_rsp_type bus_rsp;
  chip_ctrl_type ctrl;
  logic irq_out, irq_oe;
  logic [7:0] d;
  int mismatches = 0, checked = 0;
  initial forever #2 clk = ~clk;
  chip_config_rx_irq_mask dut (.clk(clk), .rst(rst), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .alarm_in(alarm_in), .ctrl(ctrl), .irq_out(irq_out),
    .irq_oe(irq_oe));
  host_bus_model host (.clk(clk), .req(bus_req), .rsp(bus_rsp));
  task complete_run;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, d);
    `CHK(d, e)
  endtask
  task irq_is(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(irq_out, e)
  endtask
  task pulse(input int i);
    @(posedge clk) alarm_in <= 7'(1 << i);
    @(posedge clk) alarm_in <= '0;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rchk(IDX_IDENT, {DIE_REVISION, PART_DIGIT});
    rchk(IDX_SETUP, SETUP_RESET);
    host.wr(IDX_SETUP, 8'hdf);
    rchk(IDX_SETUP, 8'hdf);
    @(negedge clk);
    `CHK(ctrl, 9'h1f8)
    `CHK(irq_oe, 1'b0)
    host.wr(IDX_SETUP, 8'h08);
    host.wr(IDX_RX_POWER, 8'hff);
    rchk(IDX_RX_POWER, 8'h01);
    @(negedge clk);
    `CHK({ctrl.receiver_sleep, irq_oe}, 2'b11)
    host.wr(IDX_RX_POWER, 8'h00);
    host.wr(IDX_BUF_CTRL, 8'h08);
    host.wr(IDX_MASKS, 8'hff);
    rchk(IDX_MASKS, 8'h7f);
    host.wr(IDX_BUF_CTRL, 8'h02);
    rchk(IDX_MASKS, 8'h77);
    host.wr(IDX_BUF_CTRL, 8'h00);
    host.wr(IDX_MASKS, 8'h00);
    pulse(0);
    irq_is(1'b0);
    host.wr(IDX_SETUP, 8'h28);
    for (int i = 0; i < ALARM_W; i++) begin
      host.wr(IDX_MASKS, 8'h7f & ~(8'h01 << i));
      pulse(i);
      irq_is(1'b1);
      rchk(IDX_STATUS, 8'h01 << i);
      host.wr(IDX_MASKS, 8'h7f);
      irq_is(1'b0);
      host.wr(IDX_STATUS, 8'h00);
      host.wr(IDX_MASKS, 8'h00);
      irq_is(1'b0);
    end
    pulse(6);
    irq_is(1'b1);
    host.wr(IDX_SETUP, 8'h08);
    host.wr(IDX_SETUP, 8'h28);
    irq_is(1'b0);
    complete_run;
  end
endmodule
